// [csf_host_model.sv]
// Purpose: behavioural host on the serial register port
// Assumes: the bus wire has a pull-up; scl stands still outside frames
// Notes:   each scl half lasts four clk, above the three-clk minimum
`timescale 1ns/1ps
module csf_host_model
(
   // clock
   input  wire logic clk,
   // serial wire
   input  wire logic sda_wire,
   output logic      scl = 1'b1,
   output logic      sda_drv = 1'b1
);
   logic [6:0] dev = 7'h14;

   // ********
   // bit level
   // ********
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // data moves first, then scl, so no false start or stop is seen
   task automatic step(input logic c, input logic s);
      hold(2);
      sda_drv = s;
      hold(2);
      scl = c;
   endtask
   task automatic bit_io(input logic b, output logic r);
      step(1'b1, b);
      hold(4);
      r = sda_wire;
      scl = 1'b0;
   endtask
   task automatic start;
      step(1'b1, 1'b1);
      step(1'b0, 1'b0);
   endtask
   task automatic stop;
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask

   // ********
   // byte level
   // ********
   task automatic send(input logic [7:0] v, output logic ok);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(v[i], r);
      bit_io(1'b1, r);
      ok = !r;
   endtask
   // last high answers with a nack and ends the burst, low asks for more
   task automatic recv(output logic [7:0] v, input logic last);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, v[i]);
      bit_io(last, r);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic ok);
      logic k0, k1, k2;
      start;
      send({dev, 1'b0}, k0);
      send(a, k1);
      send(v, k2);
      stop;
      ok = k0 & k1 & k2;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      logic k;
      start;
      send({dev, 1'b0}, k);
      send(a, k);
      start;
      send({dev, 1'b1}, k);
      recv(v, 1'b1);
      stop;
   endtask
   task automatic rd2(input logic [7:0] a, output logic [7:0] v0, output logic [7:0] v1);
      logic k;
      start;
      send({dev, 1'b0}, k);
      send(a, k);
      start;
      send({dev, 1'b1}, k);
      recv(v0, 1'b0);
      recv(v1, 1'b1);
      stop;
   endtask
endmodule

// [csf_pkg.sv]
// Purpose: shared constants for the charger status and fault register group
// Assumes: 25 MHz system clock, battery sense voltage delivered as millivolts
// Notes:   register offsets are byte addresses on the serial register port
package csf_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [7:0] CSF_OFS_STATUS2 = 8'h0C;
   localparam logic [7:0] CSF_OFS_FAULT   = 8'h0D;
   localparam logic [7:0] CSF_OFS_SHORT   = 8'h10;
   localparam logic [7:0] CSF_OFS_TERM    = 8'h11;

   localparam logic [7:0] CSF_RST_SHORT   = 8'h84;
   localparam logic [7:0] CSF_RST_TERM    = 8'h40;
   localparam logic [7:0] CSF_SHORT_MASK  = 8'hE7;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int CSF_ZONE_LSB    = 5;
   localparam int CSF_RCH_BIT     = 3;
   localparam int CSF_FLT_SHORT   = 3;
   localparam int CSF_FLT_OT_LOW  = 1;
   localparam int CSF_FLT_OT_HIGH = 0;
   localparam int CSF_TSEL_LSB    = 5;
   localparam int CSF_VSEL_LSB    = 0;

   localparam logic [2:0] CSF_CHG_COMPLETE = 3'h4;

   // ****************************************************************
   // battery short detection
   // ****************************************************************
   localparam logic [11:0] CSF_SHORT_BASE_MV = 12'h7D0;
   localparam logic [11:0] CSF_SHORT_STEP_MV = 12'h064;
   localparam int          CSF_CLK_HZ        = 25_000_000;
   localparam int          CSF_SEC_MS        = 1000;
   localparam int          CSF_SEC_CYCLES    = CSF_CLK_HZ / CSF_SEC_MS * CSF_SEC_MS;

   // timeout code to seconds
   function automatic logic [7:0] csf_timeout_sec(input logic [2:0] code);
      logic [7:0] s;
      s = 8'h01;
      unique case (code)
         3'h0: s = 8'h01;
         3'h1: s = 8'h02;
         3'h2: s = 8'h04;
         3'h3: s = 8'h0A;
         3'h4: s = 8'h1E;
         3'h5: s = 8'h3C;
         3'h6: s = 8'h78;
         3'h7: s = 8'hB4;
      endcase
      return s;
   endfunction

   // ****************************************************************
   // serial port states
   // ****************************************************************
   typedef enum logic [2:0]
   {
      CSF_ST_IDLE  = 3'b000,
      CSF_ST_ADDR  = 3'b001,
      CSF_ST_WRITE = 3'b010,
      CSF_ST_READ  = 3'b011,
      CSF_ST_ACK   = 3'b100,
      CSF_ST_MACK  = 3'b101
   } csf_state_t;

endpackage

// [csf_short_if.sv]
// Purpose: carries settings and result between register bank and short timer
// Assumes: all signals in the clk domain
// Notes:   none
`timescale 1ns/1ps
interface csf_short_if;
   logic [2:0]  timeout_sel;
   logic [2:0]  voltage_sel;
   logic [11:0] sense_mv;
   logic        short_detect;

   modport bank  (output timeout_sel, output voltage_sel, output sense_mv, input short_detect);
   modport timer (input timeout_sel, input voltage_sel, input sense_mv, output short_detect);
endinterface

// [csf_short_timer.sv]
// Purpose: times how long the battery stays below the short threshold
// Assumes: sense_mv is a settled millivolt reading each cycle
// Notes:   short_detect is a one-cycle pulse when the timeout elapses
`timescale 1ns/1ps
module csf_short_timer
   import csf_pkg::*;
#(
   parameter int SEC_CYCLES = CSF_SEC_CYCLES
)
(
   // clock and reset
   input wire logic  clk,
   input wire logic  nrst,
   // settings and result
   csf_short_if.timer sif
);

   logic [24:0] pre_reg;
   logic [24:0] pre_next;
   logic [7:0]  sec_reg;
   logic [7:0]  sec_next;
   logic        det_reg;
   logic [11:0] short_mv;
   logic        below;
   logic        tick;
   logic [7:0]  limit;

   // ****************************************************************
   // threshold and one-second prescaler
   // ****************************************************************
   assign short_mv = CSF_SHORT_BASE_MV
                     + 12'(CSF_SHORT_STEP_MV * {9'h000, sif.voltage_sel});
   assign below  = sif.sense_mv < short_mv;
   assign limit  = csf_timeout_sec(sif.timeout_sel);
   assign tick   = pre_reg == 25'(SEC_CYCLES - 1);

   // the prescaler restarts too, so every timeout is a full interval
   assign pre_next = (!below || tick) ? 25'h0000000 : pre_reg + 25'h0000001;
   assign sec_next = !below ? 8'h00 : (tick && sec_reg != 8'hFF) ? sec_reg + 8'h01 : sec_reg;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pre_reg <= 25'h0000000;
         sec_reg <= 8'h00;
         det_reg <= 1'b0;
      end
      else
      begin
         pre_reg <= pre_next;
         sec_reg <= sec_next;
         det_reg <= below && tick && (sec_reg + 8'h01 == limit);
      end
   end

   assign sif.short_detect = det_reg;

endmodule

// [csf_status_fault_regs.sv]
// Purpose: charger status, fault and battery short registers on a serial port
// Assumes: scl and sda inputs are already synchronous to clk
// Notes:   sda is open drain; the block only ever pulls it low
//
// Behaviour
// - thermistor zone code read in bits 7:5
// - recharge flag only when disabled and complete
// - recharge flag one when sense below threshold
// - battery level band read in bits 2:0
// - fault bit 3 latches battery short
// - fault bit 1 latches lower overtemperature
// - fault bit 0 latches upper overtemperature
// - faults held until write-one or power cycle
// - bits 7:5 select short timeout seconds
// - bits 2:0 select short voltage threshold
`timescale 1ns/1ps
module csf_status_fault_regs
   import csf_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR   = 7'h14,
   parameter int         SEC_CYCLES = CSF_SEC_CYCLES
)
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // serial register port
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   // charger state
   input  wire logic [2:0]  thermistor_zone_code,
   input  wire logic [2:0]  battery_level_code,
   input  wire logic [2:0]  charge_state_code,
   input  wire logic        recharge_disable,
   input  wire logic [11:0] battery_sense_voltage,
   input  wire logic [11:0] recharge_threshold,
   // fault sources
   input  wire logic        overtemp_lower_event,
   input  wire logic        overtemp_upper_event,
   input  wire logic        supply_input_ok,
   // fault state
   output logic             battery_short_fault,
   output logic             overtemp_lower_fault,
   output logic             overtemp_upper_fault
);

   csf_short_if sif ();

   csf_state_t  state_reg;
   logic [3:0]  cnt_reg;
   logic [7:0]  shift_reg;
   logic [7:0]  tx_reg;
   logic [7:0]  ptr_reg;
   logic        first_reg;
   logic        read_reg;
   logic        oe_reg;
   logic        sda_out_reg;
   logic        scl_prev_reg;
   logic        sda_prev_reg;
   logic        wr_reg;
   logic [7:0]  wdata_reg;
   logic [7:0]  waddr_reg;
   logic [2:0]  fault_reg;
   logic [7:0]  short_cfg_reg;
   logic [7:0]  term_cfg_reg;

   logic        scl_rise;
   logic        scl_fall;
   logic        start_cond;
   logic        stop_cond;
   logic        addr_match;
   logic        rch_active;
   logic        rch_flag;
   logic [7:0]  status2_val;
   logic [7:0]  fault_val;
   logic [7:0]  rdata;
   logic        wr_fault;
   logic        wr_short;
   logic        wr_term;
   logic [2:0]  fault_set;
   logic [2:0]  fault_clr;
   logic [2:0]  fault_next;

   // ****************************************************************
   // bus condition detection
   // ****************************************************************
   assign scl_rise   = scl_in && !scl_prev_reg;
   assign scl_fall   = !scl_in && scl_prev_reg;
   assign start_cond = scl_in && scl_prev_reg && sda_prev_reg && !sda_in;
   assign stop_cond  = scl_in && scl_prev_reg && !sda_prev_reg && sda_in;
   assign addr_match = shift_reg[7:1] == DEV_ADDR;

   // ****************************************************************
   // read view
   // ****************************************************************
   assign rch_active  = recharge_disable && (charge_state_code == CSF_CHG_COMPLETE);
   assign rch_flag    = rch_active && (battery_sense_voltage < recharge_threshold);

   assign status2_val = {thermistor_zone_code, 1'b0, rch_flag, battery_level_code};
   assign fault_val   = {4'h0, fault_reg[2], 1'b0, fault_reg[1:0]};

   assign rdata = (ptr_reg == CSF_OFS_STATUS2) ? status2_val   :
                  (ptr_reg == CSF_OFS_FAULT)   ? fault_val     :
                  (ptr_reg == CSF_OFS_SHORT)   ? short_cfg_reg :
                  (ptr_reg == CSF_OFS_TERM)    ? term_cfg_reg  :
                  8'h00;

   // ****************************************************************
   // register writes
   // ****************************************************************
   assign wr_fault = wr_reg && (waddr_reg == CSF_OFS_FAULT);
   assign wr_short = wr_reg && (waddr_reg == CSF_OFS_SHORT);
   assign wr_term  = wr_reg && (waddr_reg == CSF_OFS_TERM);

   // index 2 holds the battery short flag, 1 and 0 the overtemperature flags
   assign fault_set = {sif.short_detect, overtemp_lower_event, overtemp_upper_event};
   // low supply clears each flag whose event is not firing, so a power cycle without events leaves them empty
   assign fault_clr = (wr_fault ? {wdata_reg[CSF_FLT_SHORT], wdata_reg[CSF_FLT_OT_LOW],
                                   wdata_reg[CSF_FLT_OT_HIGH]} : 3'h0)
                      | {3{!supply_input_ok}};
   // a new event beats a clear in the same cycle
   assign fault_next = fault_set | (fault_reg & ~fault_clr);

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         fault_reg     <= 3'h0;
         short_cfg_reg <= CSF_RST_SHORT;
         term_cfg_reg  <= CSF_RST_TERM;
      end
      else
      begin
         fault_reg <= fault_next;
         if (wr_short)
         begin
            short_cfg_reg <= wdata_reg & CSF_SHORT_MASK;
         end
         if (wr_term)
         begin
            term_cfg_reg <= wdata_reg;
         end
      end
   end

   // ****************************************************************
   // battery short timer
   // ****************************************************************
   assign sif.timeout_sel = short_cfg_reg[CSF_TSEL_LSB +: 3];
   assign sif.voltage_sel = short_cfg_reg[CSF_VSEL_LSB +: 3];
   assign sif.sense_mv    = battery_sense_voltage;

   csf_short_timer #(
      .SEC_CYCLES (SEC_CYCLES)
   ) u_short_timer (
      .clk  (clk),
      .nrst (nrst),
      .sif  (sif.timer)
   );

   // ****************************************************************
   // serial port engine
   // ****************************************************************
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
         sda_out_reg  <= 1'b0;
      end
      else
      begin
         scl_prev_reg <= scl_in;
         sda_prev_reg <= sda_in;
         sda_out_reg  <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_reg <= CSF_ST_IDLE;
         cnt_reg   <= 4'h0;
         shift_reg <= 8'h00;
         tx_reg    <= 8'h00;
         ptr_reg   <= 8'h00;
         first_reg <= 1'b0;
         read_reg  <= 1'b0;
         oe_reg    <= 1'b0;
         wr_reg    <= 1'b0;
         wdata_reg <= 8'h00;
         waddr_reg <= 8'h00;
      end
      else
      begin
         wr_reg <= 1'b0;
         if (start_cond)
         begin
            state_reg <= CSF_ST_ADDR;
            cnt_reg   <= 4'h0;
            oe_reg    <= 1'b0;
         end
         else if (stop_cond)
         begin
            state_reg <= CSF_ST_IDLE;
            oe_reg    <= 1'b0;
         end
         else
         begin
            unique case (state_reg)
               CSF_ST_IDLE:
               begin
                  oe_reg <= 1'b0;
               end
               CSF_ST_ADDR, CSF_ST_WRITE:
               begin
                  if (scl_rise)
                  begin
                     shift_reg <= {shift_reg[6:0], sda_in};
                     cnt_reg   <= cnt_reg + 4'h1;
                  end
                  else if (scl_fall && cnt_reg == 4'h8)
                  begin
                     cnt_reg <= 4'h0;
                     if (state_reg == CSF_ST_ADDR)
                     begin
                        // a foreign address leaves the line alone until the next start
                        if (addr_match)
                        begin
                           oe_reg    <= 1'b1;
                           read_reg  <= shift_reg[0];
                           first_reg <= !shift_reg[0];
                           state_reg <= CSF_ST_ACK;
                        end
                        else
                        begin
                           state_reg <= CSF_ST_IDLE;
                        end
                     end
                     else
                     begin
                        oe_reg    <= 1'b1;
                        state_reg <= CSF_ST_ACK;
                        if (first_reg)
                        begin
                           ptr_reg   <= shift_reg;
                           first_reg <= 1'b0;
                        end
                        else
                        begin
                           wr_reg    <= 1'b1;
                           waddr_reg <= ptr_reg;
                           wdata_reg <= shift_reg;
                           ptr_reg   <= ptr_reg + 8'h01;
                        end
                     end
                  end
               end
               CSF_ST_ACK:
               begin
                  if (scl_fall)
                  begin
                     cnt_reg <= 4'h0;
                     if (read_reg)
                     begin
                        tx_reg    <= rdata;
                        oe_reg    <= !rdata[7];
                        state_reg <= CSF_ST_READ;
                     end
                     else
                     begin
                        oe_reg    <= 1'b0;
                        state_reg <= CSF_ST_WRITE;
                     end
                  end
               end
               CSF_ST_READ:
               begin
                  if (scl_rise)
                  begin
                     cnt_reg <= cnt_reg + 4'h1;
                  end
                  else if (scl_fall)
                  begin
                     if (cnt_reg == 4'h8)
                     begin
                        oe_reg    <= 1'b0;
                        state_reg <= CSF_ST_MACK;
                     end
                     else
                     begin
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        oe_reg <= !tx_reg[6];
                     end
                  end
               end
               CSF_ST_MACK:
               begin
                  if (scl_rise)
                  begin
                     // a not-acknowledge from the host ends the read burst
                     if (sda_in)
                     begin
                        state_reg <= CSF_ST_IDLE;
                     end
                     else
                     begin
                        ptr_reg <= ptr_reg + 8'h01;
                     end
                  end
                  else if (scl_fall)
                  begin
                     cnt_reg   <= 4'h0;
                     tx_reg    <= rdata;
                     oe_reg    <= !rdata[7];
                     state_reg <= CSF_ST_READ;
                  end
               end
               default:
               begin
                  state_reg <= CSF_ST_IDLE;
                  oe_reg    <= 1'b0;
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign sda_oe               = oe_reg;
   assign sda_out              = sda_out_reg;
   assign battery_short_fault  = fault_reg[2];
   assign overtemp_lower_fault = fault_reg[1];
   assign overtemp_upper_fault = fault_reg[0];

endmodule

// [csf_status_fault_regs_asserts.sv]
// Purpose: port-level checks on the status and fault register group
// Assumes: one clock, nrst asynchronous active low
// Notes:   threshold bound is the top short code, so it holds for any code
`timescale 1ns/1ps
module csf_status_fault_regs_asserts
   import csf_pkg::*;
#(
   parameter int SEC_CYCLES = CSF_SEC_CYCLES
)
(
   // clock and reset
   input wire logic        clk,
   input wire logic        nrst,
   // serial port
   input wire logic        scl_in,
   input wire logic        sda_oe,
   // fault sources and state
   input wire logic [11:0] battery_sense_voltage,
   input wire logic        overtemp_lower_event,
   input wire logic        overtemp_upper_event,
   input wire logic        supply_input_ok,
   input wire logic        battery_short_fault,
   input wire logic        overtemp_lower_fault,
   input wire logic        overtemp_upper_fault
);
   // ********
   // cycles below the highest short threshold
   // ********
   localparam logic [11:0] TOP_MV = 12'hA8C;
   logic [31:0] low_cnt;
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
         low_cnt <= '0;
      else if (battery_sense_voltage < TOP_MV)
         low_cnt <= low_cnt + 32'h1;
      else
         low_cnt <= '0;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence s_ot_off;
      !supply_input_ok && !overtemp_lower_event && !overtemp_upper_event;
   endsequence
   sequence s_sh_off;
      (!supply_input_ok && battery_sense_voltage >= TOP_MV) [*4];
   endsequence

   property p_lo_set;
      overtemp_lower_event |=> overtemp_lower_fault;
   endproperty
   a_lo_set: assert property (p_lo_set) else $error("lower overtemp lost");
   property p_hi_set;
      overtemp_upper_event |=> overtemp_upper_fault;
   endproperty
   a_hi_set: assert property (p_hi_set) else $error("upper overtemp lost");
   property p_ot_clr;
      s_ot_off |=> !overtemp_lower_fault && !overtemp_upper_fault;
   endproperty
   a_ot_clr: assert property (p_ot_clr) else $error("overtemp kept w/o power");
   property p_sh_clr;
      s_sh_off |=> !battery_short_fault;
   endproperty
   a_sh_clr: assert property (p_sh_clr) else $error("short kept w/o power");
   property p_hold;
      $fell(battery_short_fault) || $fell(overtemp_lower_fault) || $fell(overtemp_upper_fault)
         |-> !$past(supply_input_ok) || sda_oe || $past(sda_oe) || $past(sda_oe, 2);
   endproperty
   a_hold: assert property (p_hold) else $error("fault dropped alone");
   property p_sh_time;
      $rose(battery_short_fault) |-> $past(low_cnt) >= SEC_CYCLES - 2 || low_cnt >= SEC_CYCLES - 2;
   endproperty
   a_sh_time: assert property (p_sh_time) else $error("short set too soon");
   property p_sda_idle;
      scl_in && $past(scl_in) |-> $stable(sda_oe);
   endproperty
   a_sda_idle: assert property (p_sda_idle) else $error("sda moved with scl high");
   property p_ack_low;
      $rose(sda_oe) |-> !scl_in;
   endproperty
   a_ack_low: assert property (p_ack_low) else $error("sda pulled with scl high");
endmodule

bind csf_status_fault_regs csf_status_fault_regs_asserts #(.SEC_CYCLES(SEC_CYCLES)) u_chk
(
   .clk(clk), .nrst(nrst), .scl_in(scl_in), .sda_oe(sda_oe),
   .battery_sense_voltage(battery_sense_voltage), .supply_input_ok(supply_input_ok),
   .overtemp_lower_event(overtemp_lower_event), .overtemp_upper_event(overtemp_upper_event),
   .battery_short_fault(battery_short_fault), .overtemp_lower_fault(overtemp_lower_fault),
   .overtemp_upper_fault(overtemp_upper_fault)
);

// [csf_status_fault_regs_tb.sv]
// Purpose: self-checking bench for the status and fault register group
// Assumes: one second shortened to SEC clk cycles
// Notes:   all register traffic goes through the host model
`timescale 1ns/1ps
module csf_status_fault_regs_tb;
   import csf_pkg::*;
   localparam int SEC = 20;
   logic        clk, nrst, scl, sda_h, sda_w, sda_out, sda_oe;
   logic [2:0]  zone, lvl, chg;
   logic        rdis, ot_lo, ot_hi, sup_ok, sh_f, lo_f, hi_f, ack;
   logic [11:0] sense, rthr;
   logic [7:0]  d;
   int          num_errors, checks;

   assign sda_w = sda_h & (sda_oe ? sda_out : 1'b1);
   csf_status_fault_regs #(.SEC_CYCLES(SEC)) dut
   (
      .clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
      .sda_oe(sda_oe), .thermistor_zone_code(zone), .battery_level_code(lvl),
      .charge_state_code(chg), .recharge_disable(rdis), .battery_sense_voltage(sense),
      .recharge_threshold(rthr), .overtemp_lower_event(ot_lo), .overtemp_upper_event(ot_hi),
      .supply_input_ok(sup_ok), .battery_short_fault(sh_f), .overtemp_lower_fault(lo_f),
      .overtemp_upper_fault(hi_f)
   );
   csf_host_model host (.clk(clk), .sda_wire(sda_w), .scl(scl), .sda_drv(sda_h));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ********
   // shared tasks
   // ********
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, d);
      check(d, e);
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ********
   // scenarios
   // ********
   task automatic t_reset;
      logic [7:0] b;
      check({5'h00, sh_f, lo_f, hi_f}, 8'h00);
      rd_chk(8'h10, 8'h84);
      rd_chk(8'h11, 8'h40);
      rd_chk(8'h0D, 8'h00);
      // acked burst read walks the pointer to the next register
      host.rd2(8'h10, d, b);
      check(d, 8'h84);
      check(b, 8'h40);
      done("reset");
   endtask
   task automatic t_status;
      logic [2:0] zl [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
      for (int i = 0; i < 6; i++)
      begin
         zone = zl[i];
         lvl = (i < 5) ? 3'(i) : 3'h4;
         rd_chk(8'h0C, {zl[i], 2'b00, lvl});
      end
      done("status");
   endtask
   task automatic t_recharge;
      rdis = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         chg = 3'(i);
         rd_chk(8'h0C, {zone, 1'b0, i == 4, lvl});
      end
      chg = 3'h4;
      sense = 12'hC1C;
      rd_chk(8'h0C, {zone, 2'b00, lvl});
      sense = 12'hC1D;
      rd_chk(8'h0C, {zone, 2'b00, lvl});
      sense = 12'hC1B;
      rdis = 1'b0;
      rd_chk(8'h0C, {zone, 2'b00, lvl});
      done("recharge");
   endtask
   task automatic t_faults;
      ot_lo = 1'b1;
      ot_hi = 1'b1;
      cyc(1);
      ot_lo = 1'b0;
      ot_hi = 1'b0;
      cyc(1);
      check({5'h00, sh_f, lo_f, hi_f}, 8'h03);
      host.dev = 7'h15;
      host.wr(8'h0D, 8'hFF, ack);
      host.dev = 7'h14;
      check({7'h00, ack}, 8'h00);
      rd_chk(8'h0D, 8'h03);
      host.wr(8'h0D, 8'h01, ack);
      check({7'h00, ack}, 8'h01);
      rd_chk(8'h0D, 8'h02);
      host.wr(8'h0D, 8'h00, ack);
      host.wr(8'h20, 8'hFF, ack);
      rd_chk(8'h20, 8'h00);
      rd_chk(8'h0D, 8'h02);
      sup_ok = 1'b0;
      cyc(5);
      sup_ok = 1'b1;
      cyc(1);
      check({5'h00, sh_f, lo_f, hi_f}, 8'h00);
      done("faults");
   endtask
   task automatic t_short;
      logic [2:0]  ts [2] = '{3'h0, 3'h2};
      logic [2:0]  vs [2] = '{3'h3, 3'h7};
      int          sc [2] = '{1, 4};
      logic [11:0] th;
      int          n;
      host.wr(8'h10, 8'hFF, ack);
      rd_chk(8'h10, 8'hE7);
      for (int i = 0; i < 2; i++)
      begin
         host.wr(8'h10, {ts[i], 2'b00, vs[i]}, ack);
         th = 12'h7D0 + 12'h064 * {9'h000, vs[i]};
         sense = th;
         cyc(2 * sc[i] * SEC);
         check({5'h00, sh_f, lo_f, hi_f}, 8'h00);
         sense = th - 12'h001;
         cyc(sc[i] * SEC - 3);
         sense = th;
         cyc(1);
         sense = th - 12'h001;
         n = 0;
         while (sh_f !== 1'b1 && n < 400)
         begin
            cyc(1);
            n++;
         end
         if (n == 400)
         begin
            num_errors++;
            wrap_up;
         end
         check({7'h00, n >= sc[i] * SEC && n <= sc[i] * SEC + 2}, 8'h01);
         rd_chk(8'h0D, 8'h08);
         sense = 12'hBB8;
         host.wr(8'h0D, 8'h08, ack);
         rd_chk(8'h0D, 8'h00);
      end
      done("short");
   endtask

   initial
   begin
      nrst = 1'b0;
      zone = 3'h7;
      lvl = 3'h4;
      chg = 3'h0;
      rdis = 1'b0;
      sense = 12'hC1B;
      rthr = 12'hC1C;
      ot_lo = 1'b0;
      ot_hi = 1'b0;
      sup_ok = 1'b1;
      num_errors = 0;
      checks = 0;
      repeat (2) @(posedge clk);
      #1 nrst = 1'b1;
      cyc(2);
      t_reset;
      t_status;
      t_recharge;
      t_faults;
      t_short;
      wrap_up;
   end
endmodule
